//--- logic/jid_cfg.svh
`ifndef JID_CFG_SVH
`define JID_CFG_SVH

// instruction register
`define JID_IR_W 4
`define JID_OP_EXT_TEST 4'h0
`define JID_OP_SAMPLE 4'h1
`define JID_OP_IDENT 4'h2
`define JID_OP_HIGHZ 4'h4
`define JID_OP_BYPASS 4'hF
// capture pattern, low two bits fixed at 01
`define JID_IR_CAPTURE 4'h1

// identification register
`define JID_ID_W 32
// arbitrary neutral value, bit 0 set as the ident format needs
`define JID_ID_DEFAULT 32'h0123_4567

// bypass capture value
`define JID_BYP_CAPTURE 1'b0

// boundary pins of the default device
`define JID_NPIN 8

// clock figures
`define JID_CLK_NS 100
`define JID_TCK_MIN_NS 100

`endif

//--- logic/jid_pkg.sv
package jid_pkg;

  // test access port controller states
  typedef enum logic [3:0] {
    JID_TLR,
    JID_RTI,
    JID_SEL_DR,
    JID_CAP_DR,
    JID_SH_DR,
    JID_EX1_DR,
    JID_PAU_DR,
    JID_EX2_DR,
    JID_UPD_DR,
    JID_SEL_IR,
    JID_CAP_IR,
    JID_SH_IR,
    JID_EX1_IR,
    JID_PAU_IR,
    JID_EX2_IR,
    JID_UPD_IR
  } jid_tap_t;

  // data register between scan input and output
  typedef enum logic [1:0] {
    JID_DR_BYP,
    JID_DR_ID,
    JID_DR_BSR
  } jid_dr_sel_t;

  // decoded current instruction
  typedef struct packed {
    jid_dr_sel_t sel;
    logic ext_test;
    logic highz;
  } jid_dec_t;

  // raw scan pins from the test controller
  typedef struct packed {
    logic trst_n;
    logic tck;
    logic tms;
    logic tdi;
  } jid_link_t;

  // data register strobes for the scan cells
  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
  } jid_dr_strobe_t;

endpackage

//--- logic/jid_sync.sv
`timescale 1ns/100ps
module jid_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } jid_sync_st_t;

  jid_sync_st_t st_r;
  jid_sync_st_t st_nxt;

  // first stage feeds the second only
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule

//--- logic/jid_top.sv
`timescale 1ns/100ps
`include "jid_cfg.svh"
// Behaviour
// - instruction bits enter from scan input only in the instruction-shift state
// - instruction register is four bits wide, sixteen codes
// - code 00: external test, boundary register in scan path
// - external test: boundary cells drive pins, input cells capture pins
// - code 01: functional operation, boundary register in scan path
// - sample/preload captures functional pin values and may preload test values
// - code 02: functional, 32-bit identification register in scan path
// - identification selected after reset or any entry to test-logic-reset
// - code 04: all outputs high impedance, bypass bit in scan path
// - code 0F: functional, bypass bit from scan input to output
// - unselected data registers never disturb the core or selected register
// - current instruction alone picks the one data register in the path
// - shifted instruction becomes current only at instruction-update
// - instruction capture loads fixed pattern ending in 01
// - bypass bit loads zero at capture-data rising test clock edge
module jid_top #(
  parameter int NPIN = `JID_NPIN,
  parameter logic [`JID_ID_W-1:0] ID_CODE = `JID_ID_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // scan pins
  input wire jid_pkg::jid_link_t link_in,
  output logic tdo,
  output logic tdo_oe,
  // core side of the boundary
  input wire logic [NPIN-1:0] func_out,
  input wire logic [NPIN-1:0] func_oe,
  output logic [NPIN-1:0] core_in,
  // pad side of the boundary
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pad_out,
  output logic [NPIN-1:0] pad_oe,
  // status
  output jid_pkg::jid_tap_t tap_state,
  output logic [`JID_IR_W-1:0] instr_cur,
  output jid_pkg::jid_dec_t instr_dec,
  output jid_pkg::jid_dr_strobe_t dr_strobe
);
  import jid_pkg::*;

  localparam int IR_W = `JID_IR_W;
  localparam int ID_W = `JID_ID_W;
  // cell groups: inputs nearest the scan output, then outputs, then enables
  localparam int BSR_W = 3 * NPIN;
  localparam int SYNC_W = NPIN + 4;

  typedef struct packed {
    jid_tap_t tap;
    logic tck_d;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic byp;
    logic [ID_W-1:0] id_sh;
    logic [BSR_W-1:0] bsr_sh;
    logic [BSR_W-1:0] bsr_upd;
    logic tdo;
    logic tdo_oe;
    jid_dr_strobe_t strobe;
  } jid_state_t;

  localparam jid_state_t ST_RST = '{
    tap: JID_TLR,
    tck_d: 1'b0,
    ir_sh: `JID_IR_CAPTURE,
    ir: `JID_OP_IDENT,
    byp: `JID_BYP_CAPTURE,
    id_sh: '0,
    bsr_sh: '0,
    bsr_upd: '0,
    tdo: 1'b0,
    tdo_oe: 1'b0,
    strobe: '0
  };

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for scan pins and pad inputs

  logic [SYNC_W-1:0] sync_q;
  jid_link_t lk;
  logic [NPIN-1:0] pin_s;

  // test clock is only sampled; its period must span at least four clk cycles
  jid_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({link_in, pin_in}),
    .q(sync_q)
  );

  assign lk = sync_q[SYNC_W-1:NPIN];
  assign pin_s = sync_q[NPIN-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic jid_tap_t tap_next(input jid_tap_t s, input logic tms);
    jid_tap_t n;
    n = s;
    unique case (s)
      JID_TLR: n = tms ? JID_TLR : JID_RTI;
      JID_RTI: n = tms ? JID_SEL_DR : JID_RTI;
      JID_SEL_DR: n = tms ? JID_SEL_IR : JID_CAP_DR;
      JID_CAP_DR: n = tms ? JID_EX1_DR : JID_SH_DR;
      JID_SH_DR: n = tms ? JID_EX1_DR : JID_SH_DR;
      JID_EX1_DR: n = tms ? JID_UPD_DR : JID_PAU_DR;
      JID_PAU_DR: n = tms ? JID_EX2_DR : JID_PAU_DR;
      JID_EX2_DR: n = tms ? JID_UPD_DR : JID_SH_DR;
      JID_UPD_DR: n = tms ? JID_SEL_DR : JID_RTI;
      JID_SEL_IR: n = tms ? JID_TLR : JID_CAP_IR;
      JID_CAP_IR: n = tms ? JID_EX1_IR : JID_SH_IR;
      JID_SH_IR: n = tms ? JID_EX1_IR : JID_SH_IR;
      JID_EX1_IR: n = tms ? JID_UPD_IR : JID_PAU_IR;
      JID_PAU_IR: n = tms ? JID_EX2_IR : JID_PAU_IR;
      JID_EX2_IR: n = tms ? JID_UPD_IR : JID_SH_IR;
      JID_UPD_IR: n = tms ? JID_SEL_DR : JID_RTI;
    endcase
    return n;
  endfunction

  function automatic jid_dec_t instr_decode(input logic [IR_W-1:0] ir);
    jid_dec_t d;
    d.sel = JID_DR_BYP;
    d.ext_test = 1'b0;
    d.highz = 1'b0;
    unique case (ir)
      `JID_OP_EXT_TEST: begin
        d.sel = JID_DR_BSR;
        d.ext_test = 1'b1;
      end
      `JID_OP_SAMPLE: d.sel = JID_DR_BSR;
      `JID_OP_IDENT: d.sel = JID_DR_ID;
      `JID_OP_HIGHZ: begin
        d.sel = JID_DR_BYP;
        d.highz = 1'b1;
      end
      `JID_OP_BYPASS: d.sel = JID_DR_BYP;
      default: d.sel = JID_DR_BYP;
    endcase
    return d;
  endfunction

  // serial output bit of whichever data register the instruction picked
  function automatic logic dr_lsb(input jid_dr_sel_t sel, input logic byp, input logic [ID_W-1:0] id,
                                  input logic [BSR_W-1:0] bsr);
    logic b;
    b = byp;
    unique case (sel)
      JID_DR_BYP: b = byp;
      JID_DR_ID: b = id[0];
      JID_DR_BSR: b = bsr[0];
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // scan state

  jid_state_t st_r;
  jid_state_t st_nxt;
  jid_dec_t dec;
  logic tck_rise;
  logic tck_fall;

  assign tck_rise = lk.tck & ~st_r.tck_d;
  assign tck_fall = ~lk.tck & st_r.tck_d;

  always_comb begin
    st_nxt = st_r;
    dec = instr_decode(st_r.ir);
    st_nxt.tck_d = lk.tck;
    st_nxt.strobe = '0;
    if (!lk.trst_n) begin
      // test reset pin forces the reset state at once
      st_nxt.tap = JID_TLR;
      st_nxt.ir = `JID_OP_IDENT;
      st_nxt.tdo_oe = 1'b0;
    end else begin
      if (st_r.tap == JID_TLR) begin
        st_nxt.ir = `JID_OP_IDENT;
      end
      if (tck_rise) begin
        st_nxt.tap = tap_next(st_r.tap, lk.tms);
        if (st_r.tap == JID_CAP_IR) begin
          st_nxt.ir_sh = `JID_IR_CAPTURE;
        end
        if (st_r.tap == JID_SH_IR) begin
          st_nxt.ir_sh = {lk.tdi, st_r.ir_sh[IR_W-1:1]};
        end
        if (st_r.tap == JID_CAP_DR) begin
          st_nxt.strobe.capture = 1'b1;
          // only the selected register loads; the others keep still
          unique case (dec.sel)
            JID_DR_BYP: st_nxt.byp = `JID_BYP_CAPTURE;
            JID_DR_ID: st_nxt.id_sh = ID_CODE;
            JID_DR_BSR: st_nxt.bsr_sh = {func_oe, func_out, pin_s};
          endcase
        end
        if (st_r.tap == JID_SH_DR) begin
          st_nxt.strobe.shift = 1'b1;
          unique case (dec.sel)
            JID_DR_BYP: st_nxt.byp = lk.tdi;
            JID_DR_ID: st_nxt.id_sh = {lk.tdi, st_r.id_sh[ID_W-1:1]};
            JID_DR_BSR: st_nxt.bsr_sh = {lk.tdi, st_r.bsr_sh[BSR_W-1:1]};
          endcase
        end
      end
      if (tck_fall) begin
        if (st_r.tap == JID_UPD_IR) begin
          st_nxt.ir = st_r.ir_sh;
        end
        if (st_r.tap == JID_UPD_DR) begin
          st_nxt.strobe.update = 1'b1;
          if (dec.sel == JID_DR_BSR) begin
            // preload lands here before external test takes the pins
            st_nxt.bsr_upd = st_r.bsr_sh;
          end
        end
        // scan output changes on the falling edge, driven only while shifting
        st_nxt.tdo_oe = (st_r.tap == JID_SH_IR) || (st_r.tap == JID_SH_DR);
        if (st_r.tap == JID_SH_IR) begin
          st_nxt.tdo = st_r.ir_sh[0];
        end else if (st_r.tap == JID_SH_DR) begin
          st_nxt.tdo = dr_lsb(dec.sel, st_r.byp, st_r.id_sh, st_r.bsr_sh);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boundary muxes

  // pads pass straight through in functional mode; a register here would
  // add a cycle of latency to the core's own paths
  always_comb begin
    pad_out = func_out;
    pad_oe = func_oe;
    if (dec.highz) begin
      pad_oe = '0;
    end else if (dec.ext_test) begin
      pad_out = st_r.bsr_upd[2*NPIN-1:NPIN];
      pad_oe = st_r.bsr_upd[BSR_W-1:2*NPIN];
    end
  end

  // core keeps seeing the live pins, even under external test
  assign core_in = pin_in;

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign tdo = st_r.tdo;
  assign tdo_oe = st_r.tdo_oe;
  assign tap_state = st_r.tap;
  assign instr_cur = st_r.ir;
  assign instr_dec = dec;
  assign dr_strobe = st_r.strobe;

endmodule

//--- testbench/jid_top_chk.sv
`timescale 1ns/100ps
`include "jid_cfg.svh"
module jid_chk #(
  parameter int NPIN = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // boundary
  input wire logic [NPIN-1:0] func_out,
  input wire logic [NPIN-1:0] func_oe,
  input wire logic [NPIN-1:0] core_in,
  input wire logic [NPIN-1:0] pin_in,
  input wire logic [NPIN-1:0] pad_out,
  input wire logic [NPIN-1:0] pad_oe,
  // status
  input wire jid_pkg::jid_tap_t tap_state,
  input wire logic [`JID_IR_W-1:0] instr_cur,
  input wire jid_pkg::jid_dec_t instr_dec,
  // scan output and data register strobes
  input wire logic tdo_oe,
  input wire jid_pkg::jid_dr_strobe_t dr_strobe
);
  import jid_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////
  property p_ir_hold;
    $changed(instr_cur) |-> $past(tap_state) inside {JID_UPD_IR, JID_TLR} || tap_state == JID_TLR;
  endproperty
  property p_tlr;
    tap_state == JID_TLR |=> instr_cur == `JID_OP_IDENT;
  endproperty
  property p_id;
    instr_cur == `JID_OP_IDENT |-> instr_dec.sel == JID_DR_ID && !instr_dec.ext_test;
  endproperty
  property p_bsr;
    instr_cur inside {`JID_OP_EXT_TEST, `JID_OP_SAMPLE} |-> instr_dec.sel == JID_DR_BSR;
  endproperty
  property p_byp;
    !(instr_cur inside {4'h0, 4'h1, 4'h2}) |-> instr_dec.sel == JID_DR_BYP && !instr_dec.ext_test;
  endproperty
  property p_ext;
    instr_cur == `JID_OP_EXT_TEST |-> instr_dec.ext_test && !instr_dec.highz;
  endproperty
  property p_highz;
    instr_cur == `JID_OP_HIGHZ |-> pad_oe == '0;
  endproperty
  property p_func;
    !(instr_cur inside {4'h0, 4'h4}) |-> pad_out == func_out && pad_oe == func_oe;
  endproperty
  property p_core;
    core_in == pin_in;
  endproperty
  // scan output driven only from a shift state until the next falling edge
  property p_tdo_oe;
    tdo_oe |-> tap_state inside {JID_SH_IR, JID_EX1_IR, JID_SH_DR, JID_EX1_DR};
  endproperty
  property p_cap;
    dr_strobe.capture |-> $past(tap_state) == JID_CAP_DR;
  endproperty
  property p_upd;
    dr_strobe.update |-> tap_state == JID_UPD_DR;
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("instruction changed outside update");
  a_tlr: assert property (p_tlr) else $error("reset state did not restore ident");
  a_id: assert property (p_id) else $error("ident decode wrong");
  a_bsr: assert property (p_bsr) else $error("boundary not selected");
  a_byp: assert property (p_byp) else $error("bypass not selected");
  a_ext: assert property (p_ext) else $error("external test decode wrong");
  a_highz: assert property (p_highz) else $error("outputs enabled in high-z");
  a_func: assert property (p_func) else $error("pads not functional");
  a_core: assert property (p_core) else $error("core input disturbed");
  a_tdo_oe: assert property (p_tdo_oe) else $error("scan output driven outside shift");
  a_cap: assert property (p_cap) else $error("capture strobe outside capture");
  a_upd: assert property (p_upd) else $error("update strobe outside update");
  c_ext: cover property (instr_cur == `JID_OP_EXT_TEST);
  c_hz: cover property (instr_cur == `JID_OP_HIGHZ);
  c_upd: cover property (tap_state == JID_UPD_DR);
endmodule

bind jid_top jid_chk #(.NPIN(NPIN)) u_chk (.*);

//--- testbench/jid_ctl.sv
`timescale 1ns/100ps
module jid_ctl (
  // clock
  input wire logic clk,
  // scan pins
  input wire logic tdo,
  output jid_pkg::jid_link_t link
);
  import jid_pkg::*;
  initial link = '{trst_n: 1'b1, tck: 1'b0, tms: 1'b1, tdi: 1'b0};
  // tck of 8 clk, low 5 so tdo has settled; still between frames
  task automatic step(input logic tms, input logic tdi, output logic so);
    @(posedge clk);
    link.tms <= tms;
    link.tdi <= tdi;
    repeat (4) @(posedge clk);
    so = tdo;
    link.tck <= 1'b1;
    repeat (3) @(posedge clk);
    link.tck <= 1'b0;
    // no stale bit on a released data line
    link.tdi <= ~tdi;
  endtask
  task automatic go(input logic [3:0] tms, input int n);
    logic so;
    for (int i = 0; i < n; i++) begin
      step(tms[i], 1'b0, so);
    end
  endtask
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
  endtask
  // from run-test-idle back to run-test-idle
  task automatic load_ir(input logic [3:0] code, output logic [3:0] cap);
    logic [31:0] d;
    go(4'h3, 4);
    shift(4, {28'h0, code}, d);
    go(4'h1, 2);
    cap = d[3:0];
  endtask
  task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    go(4'h1, 3);
    shift(n, din, dout);
    go(4'h1, 2);
  endtask
  task automatic trst_pulse;
    @(posedge clk);
    link.trst_n <= 1'b0;
    repeat (4) @(posedge clk);
    link.trst_n <= 1'b1;
    repeat (4) @(posedge clk);
    go(4'h0, 1);
  endtask
endmodule

//--- testbench/testbench.sv
`timescale 1ns/100ps
`include "jid_cfg.svh"
module testbench;
  import jid_pkg::*;
  localparam int NPIN = 2;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  jid_link_t link_in;
  logic tdo;
  logic tdo_oe;
  logic [NPIN-1:0] func_out = '0;
  logic [NPIN-1:0] func_oe = '0;
  logic [NPIN-1:0] pin_in = '0;
  logic [NPIN-1:0] core_in;
  logic [NPIN-1:0] pad_out;
  logic [NPIN-1:0] pad_oe;
  jid_tap_t tap_state;
  logic [`JID_IR_W-1:0] instr_cur;
  jid_dec_t instr_dec;
  jid_dr_strobe_t dr_strobe;
  int num_errors = 0;
  int num_checks = 0;
  logic [31:0] d;
  logic [3:0] cap;
  always #50 clk = ~clk;
  jid_top #(.NPIN(NPIN)) uut (.*);
  jid_ctl ctl (.clk(clk), .tdo(tdo), .link(link_in));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_reset;
    check("ir", instr_cur, `JID_OP_IDENT);
    ctl.go(4'h0, 1);
    ctl.scan_dr(32, 32'h0, d);
    check("id", d, `JID_ID_DEFAULT);
    $display("reset test done");
  endtask
  // preload lands before external test is chosen
  task automatic t_sample;
    @(posedge clk);
    pin_in <= 2'b10;
    func_out <= 2'b01;
    func_oe <= 2'b11;
    ctl.load_ir(`JID_OP_SAMPLE, cap);
    check("cap", cap, `JID_IR_CAPTURE);
    check("ir", instr_cur, `JID_OP_SAMPLE);
    // state register moves on the edge the last step returns at
    @(posedge clk);
    check("tap", tap_state, JID_RTI);
    ctl.scan_dr(6, 32'h18, d);
    check("smp", d[5:0], 6'h36);
    check("pad", pad_out, func_out);
    $display("sample test done");
  endtask
  task automatic t_extest;
    ctl.load_ir(`JID_OP_EXT_TEST, cap);
    check("pad", pad_out, 2'b10);
    check("oe", pad_oe, 2'b01);
    @(posedge clk);
    pin_in <= 2'b01;
    ctl.scan_dr(6, 32'h18, d);
    check("ext", d[5:0], 6'h35);
    $display("extest done");
  endtask
  task automatic t_bypass;
    logic [3:0] codes [4] = '{4'hF, 4'h7, 4'h4, 4'h3};
    foreach (codes[i]) begin
      ctl.load_ir(codes[i], cap);
      check("sel", instr_dec.sel, JID_DR_BYP);
      check("oe", pad_oe, codes[i] == `JID_OP_HIGHZ ? 2'b00 : func_oe);
      ctl.scan_dr(8, 32'hA5, d);
      check("byp", d[7:0], 8'h4A);
    end
    $display("bypass test done");
  endtask
  task automatic t_trst;
    ctl.trst_pulse();
    check("ir", instr_cur, `JID_OP_IDENT);
    ctl.scan_dr(32, 32'h0, d);
    check("id", d, `JID_ID_DEFAULT);
    $display("test reset done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_sample();
    t_extest();
    t_bypass();
    t_trst();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule
